/* nts_consts.vh */
`ifndef NTS_CONSTS_VH
`define NTS_CONSTS_VH

// Direct command codes on CMD_CODE.
`define NTS_CMD_CLEAR 3'h0
`define NTS_CMD_TX_CRC 3'h1
`define NTS_CMD_TX_NOCRC 3'h2
`define NTS_CMD_REQA 3'h3
`define NTS_CMD_WUPA 3'h4
`define NTS_CMD_PRESET 3'h5

// Short frames, seven bits each, sent without parity or CRC.
`define NTS_SHORT_REQA 9'h026
`define NTS_SHORT_WUPA 9'h052
`define NTS_SHORT_BITS 4'h7

// Bits per full byte on air: eight data bits and odd parity.
`define NTS_BYTE_BITS 4'h9
`define NTS_CRC_BYTES 2'h2

// CRC of the 14443A kind, reflected polynomial and preset.
`define NTS_CRC_POLY 16'h8408
`define NTS_CRC_INIT 16'h6363

// Receiver and transmitter option sets loaded by the analog preset, per mode.
`define NTS_PRESET_M0 8'h11
`define NTS_PRESET_M1 8'h22
`define NTS_PRESET_M2 8'h44
`define NTS_PRESET_M3 8'h88

// Error flag positions.
`define NTS_ERR_CRC 0
`define NTS_ERR_FRAME 1
`define NTS_ERR_OVF 2

// Sequencer states, one-hot.
`define NTS_ST_IDLE 5'h01
`define NTS_ST_TX 5'h02
`define NTS_ST_MASK 5'h04
`define NTS_ST_LISTEN 5'h08
`define NTS_ST_RX 5'h10

`endif

/* nts_fifo.v */
`timescale 1ns/10ps
`default_nettype none

module nts_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    input wire clr,
    // Fill side
    input wire in_valid,
    input wire [WIDTH-1:0] in_data,
    output wire in_ready,
    // Drain side
    output wire out_valid,
    output wire [WIDTH-1:0] out_data,
    input wire out_ready,
    // Fill level
    output wire [AW:0] count
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire do_wr = in_valid & in_ready;
    wire do_rd = out_valid & out_ready;

    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_reg];
    assign count = count_reg;

    always @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (rst || clr) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count_reg <= count_reg + 1'b1;
            end else if (do_rd && !do_wr) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // nts_fifo

`default_nettype wire

/* nts_sequencer.v */
`timescale 1ns/10ps
`default_nettype none
`include "nts_consts.vh"

module nts_sequencer #(
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire CORE_CLK,
    input wire RST,
    // Configuration
    input wire [1:0] MODE,
    input wire EN,
    input wire RX_EN,
    input wire TX_EN,
    input wire ANTCL,
    input wire NO_CRC_RX,
    input wire [12:0] TX_COUNT,
    input wire [2:0] TX_BITS,
    input wire [7:0] MASK_RECEIVE_TIMER,
    input wire [15:0] NO_RESPONSE_TIMER,
    input wire [AW:0] TX_WATER,
    input wire [AW:0] RX_WATER,
    // Commands
    input wire CMD_VALID,
    input wire [2:0] CMD_CODE,
    // Host FIFO access
    input wire WR_VALID,
    input wire [7:0] WR_DATA,
    output wire WR_READY,
    output wire RD_VALID,
    output wire [7:0] RD_DATA,
    input wire RD_READY,
    // RF link
    input wire LINK_CLK,
    input wire RX_DATA,
    input wire RX_FRAME,
    input wire RX_COLL,
    input wire RX_CODE_ERR,
    input wire OSC_OK,
    output reg TX_DATA,
    output reg TX_ACTIVE,
    output reg RX_ON,
    // Status and events
    output reg READY,
    output reg [7:0] PRESET_OPTS,
    output reg [AW:0] FIFO_COUNT,
    output reg [2:0] ERR_FLAGS,
    output reg IRQ_OSC,
    output reg IRQ_TXE,
    output reg IRQ_RXE,
    output reg IRQ_ERR,
    output reg IRQ_COL,
    output reg IRQ_WL,
    output reg IRQ_NRE
);
    function [15:0] crc_byte;
        input [15:0] c;
        input [7:0] d;
        integer i;
        reg [15:0] x;
        begin
            x = c;
            for (i = 0; i < 8; i = i + 1) begin
                x = (x[0] ^ d[i]) ? ((x >> 1) ^ `NTS_CRC_POLY) : (x >> 1);
            end
            crc_byte = x;
        end
    endfunction

    // Pin inputs pass two flip-flops; only the second stage is read.
    reg [5:0] s1_reg;
    reg [5:0] s2_reg;
    reg lk_d_reg;
    reg fr_d_reg;
    reg [4:0] state_reg;
    reg [8:0] sr_reg;
    reg [3:0] left_reg;
    reg [12:0] byte_left_reg;
    reg [1:0] crc_left_reg;
    reg crc_on_reg;
    reg [15:0] crc_reg;
    reg [7:0] mrt_reg;
    reg [15:0] nrt_reg;
    reg [7:0] rsr_reg;
    reg [2:0] rn_reg;
    reg push_v_reg;
    reg [7:0] push_d_reg;
    reg end_pend_reg;
    reg [3:0] ld_n;
    reg [8:0] ld_sr;
    reg ld_ok;
    reg ld_pop;
    reg [7:0] cb;

    wire link_rise = s2_reg[0] & ~lk_d_reg;
    wire rx_bit = s2_reg[1];
    wire frame_rise = s2_reg[2] & ~fr_d_reg;
    wire frame_fall = ~s2_reg[2] & fr_d_reg;
    wire ready_now = EN & s2_reg[5];
    wire in_tx = state_reg[1];
    wire rx_mode = state_reg[4] | push_v_reg | end_pend_reg;
    wire cmd_ok = CMD_VALID & READY & RX_EN & TX_EN & state_reg[0];
    wire f_in_ready;
    wire f_out_valid;
    wire [7:0] f_out_data;
    wire [AW:0] f_count;
    wire f_clr = CMD_VALID & (CMD_CODE == `NTS_CMD_CLEAR);
    wire pop = in_tx & link_rise & (left_reg == 4'h0) & ld_pop;
    wire push_ok = push_v_reg & f_in_ready;

    assign WR_READY = f_in_ready & ~rx_mode;
    assign RD_VALID = f_out_valid & ~in_tx;
    assign RD_DATA = f_out_data;

    nts_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_fifo (
        .clk(CORE_CLK),
        .rst(RST),
        .clr(f_clr),
        .in_valid(rx_mode ? push_v_reg : WR_VALID),
        .in_data(rx_mode ? push_d_reg : WR_DATA),
        .in_ready(f_in_ready),
        .out_valid(f_out_valid),
        .out_data(f_out_data),
        .out_ready(in_tx ? pop : RD_READY),
        .count(f_count)
    );

    // Next unit to put on air: a FIFO byte with parity, or a CRC byte.
    always @* begin
        ld_ok = 1'b0;
        ld_pop = 1'b0;
        ld_sr = 9'h000;
        ld_n = 4'h0;
        cb = (crc_left_reg == `NTS_CRC_BYTES) ? crc_reg[7:0] : crc_reg[15:8];
        if (byte_left_reg != 13'h0000) begin
            ld_ok = f_out_valid;
            ld_pop = f_out_valid;
            ld_sr = {~^f_out_data, f_out_data};
            // Without CRC, a trailing partial byte goes out without parity; its pad bits never leave.
            if (byte_left_reg == 13'h0001 && !crc_on_reg && TX_BITS != 3'h0) begin
                ld_n = {1'b0, TX_BITS};
            end else begin
                ld_n = `NTS_BYTE_BITS;
            end
        end else if (crc_left_reg != 2'h0) begin
            ld_ok = 1'b1;
            ld_sr = {~^cb, cb};
            ld_n = `NTS_BYTE_BITS;
        end
    end

    always @(posedge CORE_CLK) begin
        if (RST) begin
            s1_reg <= 6'h00;
            s2_reg <= 6'h00;
            lk_d_reg <= 1'b0;
            fr_d_reg <= 1'b0;
            state_reg <= `NTS_ST_IDLE;
            sr_reg <= 9'h000;
            left_reg <= 4'h0;
            byte_left_reg <= 13'h0000;
            crc_left_reg <= 2'h0;
            crc_on_reg <= 1'b0;
            crc_reg <= `NTS_CRC_INIT;
            mrt_reg <= 8'h00;
            nrt_reg <= 16'h0000;
            rsr_reg <= 8'h00;
            rn_reg <= 3'h0;
            push_v_reg <= 1'b0;
            push_d_reg <= 8'h00;
            end_pend_reg <= 1'b0;
            TX_DATA <= 1'b0;
            TX_ACTIVE <= 1'b0;
            RX_ON <= 1'b0;
            READY <= 1'b0;
            PRESET_OPTS <= 8'h00;
            FIFO_COUNT <= {(AW+1){1'b0}};
            ERR_FLAGS <= 3'h0;
            IRQ_OSC <= 1'b0;
            IRQ_TXE <= 1'b0;
            IRQ_RXE <= 1'b0;
            IRQ_ERR <= 1'b0;
            IRQ_COL <= 1'b0;
            IRQ_WL <= 1'b0;
            IRQ_NRE <= 1'b0;
        end else begin
            s1_reg <= {OSC_OK, RX_CODE_ERR, RX_COLL, RX_FRAME, RX_DATA, LINK_CLK};
            s2_reg <= s1_reg;
            lk_d_reg <= s2_reg[0];
            fr_d_reg <= s2_reg[2];
            FIFO_COUNT <= f_count;
            READY <= ready_now;
            IRQ_OSC <= ready_now & ~READY;
            IRQ_TXE <= 1'b0;
            IRQ_RXE <= 1'b0;
            IRQ_ERR <= 1'b0;
            IRQ_COL <= 1'b0;
            IRQ_NRE <= 1'b0;
            // Water level events fire once, on the crossing itself.
            IRQ_WL <= (in_tx & pop & (f_count == TX_WATER) & (byte_left_reg > 13'h0001))
                | (rx_mode & push_ok & (f_count == RX_WATER));
            if (push_ok) begin
                push_v_reg <= 1'b0;
            end
            if (CMD_VALID && CMD_CODE == `NTS_CMD_PRESET) begin
                case (MODE)
                    2'h0: PRESET_OPTS <= `NTS_PRESET_M0;
                    2'h1: PRESET_OPTS <= `NTS_PRESET_M1;
                    2'h2: PRESET_OPTS <= `NTS_PRESET_M2;
                    default: PRESET_OPTS <= `NTS_PRESET_M3;
                endcase
            end
            if (f_clr) begin
                state_reg <= `NTS_ST_IDLE;
                TX_ACTIVE <= 1'b0;
                RX_ON <= 1'b0;
                ERR_FLAGS <= 3'h0;
                push_v_reg <= 1'b0;
                end_pend_reg <= 1'b0;
            end else begin
                case (state_reg)
                    `NTS_ST_IDLE: begin
                        if (cmd_ok && (CMD_CODE == `NTS_CMD_REQA || CMD_CODE == `NTS_CMD_WUPA)) begin
                            state_reg <= `NTS_ST_TX;
                            TX_ACTIVE <= 1'b1;
                            sr_reg <= (CMD_CODE == `NTS_CMD_REQA) ? `NTS_SHORT_REQA : `NTS_SHORT_WUPA;
                            left_reg <= `NTS_SHORT_BITS;
                            byte_left_reg <= 13'h0000;
                            crc_left_reg <= 2'h0;
                            ERR_FLAGS <= 3'h0;
                        end else if (cmd_ok && (CMD_CODE == `NTS_CMD_TX_CRC ||
                                                CMD_CODE == `NTS_CMD_TX_NOCRC)) begin
                            state_reg <= `NTS_ST_TX;
                            TX_ACTIVE <= 1'b1;
                            left_reg <= 4'h0;
                            byte_left_reg <= TX_COUNT;
                            crc_on_reg <= (CMD_CODE == `NTS_CMD_TX_CRC);
                            crc_left_reg <= (CMD_CODE == `NTS_CMD_TX_CRC) ? `NTS_CRC_BYTES : 2'h0;
                            crc_reg <= `NTS_CRC_INIT;
                            ERR_FLAGS <= 3'h0;
                        end
                    end
                    `NTS_ST_TX: begin
                        if (link_rise) begin
                            if (left_reg != 4'h0) begin
                                TX_DATA <= sr_reg[0];
                                sr_reg <= sr_reg >> 1;
                                left_reg <= left_reg - 4'h1;
                            end else if (ld_ok) begin
                                // Load and send the first bit on the same link edge.
                                TX_DATA <= ld_sr[0];
                                sr_reg <= ld_sr >> 1;
                                left_reg <= ld_n - 4'h1;
                                if (ld_pop) begin
                                    byte_left_reg <= byte_left_reg - 13'h0001;
                                    crc_reg <= crc_byte(crc_reg, f_out_data);
                                end else begin
                                    crc_left_reg <= crc_left_reg - 2'h1;
                                end
                            end else if (byte_left_reg == 13'h0000) begin
                                // With no bytes or CRC left, end the frame and start the mask timer; an empty FIFO mid-frame only stalls.
                                TX_ACTIVE <= 1'b0;
                                TX_DATA <= 1'b0;
                                IRQ_TXE <= 1'b1;
                                state_reg <= `NTS_ST_MASK;
                                mrt_reg <= MASK_RECEIVE_TIMER;
                                nrt_reg <= NO_RESPONSE_TIMER;
                                crc_reg <= `NTS_CRC_INIT;
                                rn_reg <= 3'h0;
                            end
                        end
                    end
                    `NTS_ST_MASK, `NTS_ST_LISTEN: begin
                        // Each rising link clock edge, one bit period, is one timer step.
                        if (link_rise && mrt_reg != 8'h00) begin
                            mrt_reg <= mrt_reg - 8'h01;
                        end
                        if (link_rise && nrt_reg != 16'h0000) begin
                            nrt_reg <= nrt_reg - 16'h0001;
                        end
                        if (state_reg[2] && mrt_reg == 8'h00) begin
                            state_reg <= `NTS_ST_LISTEN;
                            RX_ON <= 1'b1;
                        end else if (state_reg[3] && frame_rise) begin
                            state_reg <= `NTS_ST_RX;
                        end else if (link_rise && nrt_reg == 16'h0001) begin
                            state_reg <= `NTS_ST_IDLE;
                            RX_ON <= 1'b0;
                            IRQ_NRE <= 1'b1;
                        end
                    end
                    `NTS_ST_RX: begin
                        if (link_rise && s2_reg[2]) begin
                            rsr_reg <= {rx_bit, rsr_reg[7:1]};
                            rn_reg <= rn_reg + 3'h1;
                            if (s2_reg[3]) begin
                                IRQ_COL <= 1'b1;
                                if (!ANTCL) begin
                                    ERR_FLAGS[`NTS_ERR_FRAME] <= 1'b1;
                                    IRQ_ERR <= 1'b1;
                                end
                            end
                            if (s2_reg[4]) begin
                                ERR_FLAGS[`NTS_ERR_FRAME] <= 1'b1;
                                IRQ_ERR <= 1'b1;
                            end
                            if (rn_reg == 3'h7) begin
                                push_v_reg <= 1'b1;
                                push_d_reg <= {rx_bit, rsr_reg[7:1]};
                                crc_reg <= crc_byte(crc_reg, {rx_bit, rsr_reg[7:1]});
                                if (push_v_reg && !push_ok) begin
                                    ERR_FLAGS[`NTS_ERR_OVF] <= 1'b1;
                                    IRQ_ERR <= 1'b1;
                                end
                            end
                        end else if (frame_fall) begin
                            // A split byte lands right-justified; upper bits are not valid.
                            if (rn_reg != 3'h0) begin
                                push_v_reg <= 1'b1;
                                push_d_reg <= rsr_reg >> (4'h8 - {1'b0, rn_reg});
                            end else if (!NO_CRC_RX && crc_reg != 16'h0000) begin
                                ERR_FLAGS[`NTS_ERR_CRC] <= 1'b1;
                                IRQ_ERR <= 1'b1;
                            end
                            end_pend_reg <= 1'b1;
                            RX_ON <= 1'b0;
                            state_reg <= `NTS_ST_IDLE;
                        end
                    end
                    default: state_reg <= `NTS_ST_IDLE;
                endcase
                // End of receive waits until the last byte is in the FIFO.
                if (end_pend_reg && !push_v_reg) begin
                    end_pend_reg <= 1'b0;
                    IRQ_RXE <= 1'b1;
                end
            end
        end
    end
endmodule // nts_sequencer

`default_nettype wire

/* nts_sequencer_properties.sv */
`timescale 1ns/10ps
`default_nettype none
`include "nts_consts.vh"

module nts_chk (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Configuration and commands
    input wire logic [1:0] MODE,
    input wire logic EN,
    input wire logic RX_EN,
    input wire logic TX_EN,
    input wire logic ANTCL,
    input wire logic [7:0] MASK_RECEIVE_TIMER,
    input wire logic CMD_VALID,
    input wire logic [2:0] CMD_CODE,
    // Watched outputs
    input wire logic TX_ACTIVE,
    input wire logic RX_ON,
    input wire logic READY,
    input wire logic [7:0] PRESET_OPTS,
    input wire logic [2:0] ERR_FLAGS,
    input wire logic IRQ_TXE,
    input wire logic IRQ_COL
);
    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    property p_preset;
        CMD_VALID && CMD_CODE == `NTS_CMD_PRESET |=> PRESET_OPTS == (8'h11 << $past(MODE));
    endproperty
    a_preset: assert property (p_preset) else $error("preset options wrong");
    property p_ready;
        !EN |=> !READY;
    endproperty
    a_ready: assert property (p_ready) else $error("ready without enable");
    property p_short;
        CMD_VALID && CMD_CODE == `NTS_CMD_REQA && READY && RX_EN && TX_EN && !TX_ACTIVE
            && !RX_ON |=> TX_ACTIVE;
    endproperty
    a_short: assert property (p_short) else $error("short frame not started");
    property p_txe;
        $fell(TX_ACTIVE) |-> ##[0:2] IRQ_TXE;
    endproperty
    a_txe: assert property (p_txe) else $error("no end of transmit event");
    property p_mask;
        $fell(TX_ACTIVE) && MASK_RECEIVE_TIMER > 8'h01 |-> !RX_ON [*8];
    endproperty
    a_mask: assert property (p_mask) else $error("receiver opened during mask");
    property p_coll_err;
        IRQ_COL && !ANTCL |-> ##[0:2] ERR_FLAGS[`NTS_ERR_FRAME];
    endproperty
    a_coll_err: assert property (p_coll_err) else $error("collision not flagged");
    property p_antcl;
        IRQ_COL && ANTCL |-> !$rose(ERR_FLAGS[1]) ##1 !$rose(ERR_FLAGS[1]);
    endproperty
    a_antcl: assert property (p_antcl) else $error("framing error in anticollision");
    property p_clear;
        CMD_VALID && CMD_CODE == `NTS_CMD_CLEAR |=> ERR_FLAGS == 3'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left error flags");
    c_txe: cover property (IRQ_TXE);
    c_col: cover property (IRQ_COL && ANTCL);
    c_preset: cover property (CMD_VALID && CMD_CODE == `NTS_CMD_PRESET && MODE == 2'h3);
endmodule // nts_chk

bind nts_sequencer nts_chk u_chk (.CORE_CLK, .RST, .MODE, .EN, .RX_EN, .TX_EN, .ANTCL,
    .MASK_RECEIVE_TIMER, .CMD_VALID, .CMD_CODE, .TX_ACTIVE, .RX_ON, .READY, .PRESET_OPTS,
    .ERR_FLAGS, .IRQ_TXE, .IRQ_COL);
`default_nettype wire

/* nts_tag_model.sv */
`timescale 1ns/10ps
`default_nettype none

module nts_tag_model (
    // Reader side
    input wire logic field_on,
    input wire logic tx_active,
    // Reply set-up
    input wire logic [4:0] reply_len,
    input wire logic [15:0] reply,
    input wire logic [4:0] coll_idx,
    // Demodulated link
    output logic link_clk,
    output logic rx_data,
    output logic rx_frame,
    output logic rx_coll,
    output logic rx_code_err
);
    // The carrier runs while the field is on, since the reader's timers count it.
    initial begin
        link_clk = 1'b0;
        #7;
        forever begin
            #100;
            link_clk = field_on ? ~link_clk : 1'b0;
        end
    end
    initial begin
        rx_data = 1'b0;
        rx_frame = 1'b0;
        rx_coll = 1'b0;
        rx_code_err = 1'b0;
    end
    // Bits change mid-period so that the reader samples them settled.
    always @(negedge tx_active) begin
        if (reply_len != 5'h00) begin
            repeat (8) @(posedge link_clk);
            for (int i = 0; i < reply_len; i++) begin
                @(negedge link_clk);
                rx_frame = 1'b1;
                rx_data = reply[i];
                rx_coll = (i == coll_idx);
            end
            @(negedge link_clk);
            rx_frame = 1'b0;
            rx_coll = 1'b0;
            rx_data = ~rx_data;
        end
    end
endmodule // nts_tag_model
`default_nettype wire

/* tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "nts_consts.vh"

module tb;
    logic CORE_CLK, RST, EN, RX_EN, TX_EN, ANTCL, NO_CRC_RX, OSC_OK, CMD_VALID, WR_VALID, RD_READY;
    logic [1:0] MODE;
    logic [2:0] CMD_CODE, TX_BITS;
    logic [7:0] MASK_RECEIVE_TIMER, WR_DATA, d;
    logic [12:0] TX_COUNT;
    logic [15:0] NO_RESPONSE_TIMER, rpat, crc;
    logic [4:0] TX_WATER, RX_WATER, rlen, cidx;
    wire LINK_CLK, RX_DATA, RX_FRAME, RX_COLL, RX_CODE_ERR, WR_READY, RD_VALID;
    wire TX_DATA, TX_ACTIVE, RX_ON, READY, IRQ_OSC, IRQ_TXE, IRQ_RXE, IRQ_ERR, IRQ_COL;
    wire IRQ_WL, IRQ_NRE;
    wire [7:0] RD_DATA, PRESET_OPTS;
    wire [4:0] FIFO_COUNT;
    wire [2:0] ERR_FLAGS;
    wire [6:0] irqs = {IRQ_NRE, IRQ_WL, IRQ_COL, IRQ_ERR, IRQ_RXE, IRQ_TXE, IRQ_OSC};
    int fail_count = 0;
    int n_compared = 0;
    int irq_cnt [7] = '{default: 0};
    int b [7];
    logic bit_q [$];
    logic [7:0] byte_q [$];
    logic armed = 1'b0;
    nts_sequencer dut (.*);
    nts_tag_model tag (.field_on(TX_EN), .tx_active(TX_ACTIVE), .reply_len(rlen), .reply(rpat),
        .coll_idx(cidx), .link_clk(LINK_CLK), .rx_data(RX_DATA), .rx_frame(RX_FRAME),
        .rx_coll(RX_COLL), .rx_code_err(RX_CODE_ERR));
    initial begin
        CORE_CLK = 1'b0;
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    function automatic logic [15:0] crc_a(input logic [15:0] c, input logic [7:0] v);
        for (int j = 0; j < 8; j++)
            c = (c[0] ^ v[j]) ? ((c >> 1) ^ `NTS_CRC_POLY) : (c >> 1);
        return c;
    endfunction
    task automatic push_byte(input logic [7:0] v);
        for (int j = 0; j < 8; j++)
            bit_q.push_back(v[j]);
        bit_q.push_back(~^v);
    endtask
    task automatic put(input logic [7:0] v);
        @(negedge CORE_CLK);
        WR_DATA = v;
        WR_VALID = 1'b1;
        push_byte(v);
    endtask
    task automatic cmd(input logic [2:0] code);
        // With the field on, commands land just after a link fall so a frame never starts mid-bit.
        if (TX_EN)
            @(negedge LINK_CLK);
        @(negedge CORE_CLK);
        CMD_CODE = code;
        CMD_VALID = 1'b1;
        @(negedge CORE_CLK);
        CMD_VALID = 1'b0;
    endtask
    task automatic wait_irq(input int k, input int n);
        repeat (4000) begin
            @(negedge CORE_CLK);
            if (irq_cnt[k] >= n)
                return;
        end
        check(irq_cnt[k], n);
    endtask
    task automatic send(input logic [2:0] code);
        logic [8:0] s;
        s = (code == `NTS_CMD_WUPA) ? `NTS_SHORT_WUPA : `NTS_SHORT_REQA;
        if (code >= `NTS_CMD_REQA)
            for (int j = 0; j < 7; j++)
                bit_q.push_back(s[j]);
        b = irq_cnt;
        cmd(code);
        wait_irq(1, b[1] + 1);
        check(bit_q.size(), 0);
    endtask
    task automatic drain();
        @(negedge CORE_CLK);
        RD_READY = 1'b1;
        repeat (20) @(negedge CORE_CLK);
        RD_READY = 1'b0;
        check(byte_q.size(), 0);
        check(FIFO_COUNT, 5'h00);
    endtask
    always @(posedge CORE_CLK) begin
        for (int k = 0; k < 7; k++)
            irq_cnt[k] += irqs[k];
        if (RD_VALID && RD_READY)
            check(RD_DATA, byte_q.pop_front());
    end
    always @(posedge LINK_CLK) begin
        if (armed && TX_ACTIVE)
            check(TX_DATA, bit_q.pop_front());
        armed = TX_ACTIVE;
    end
    initial begin
        #1000000;
        $display("watchdog expired");
        fail_count++;
        tally_and_finish();
    end
    initial begin
        {RST, EN, RX_EN, TX_EN, ANTCL, NO_CRC_RX, OSC_OK, CMD_VALID, WR_VALID, RD_READY} = 10'h200;
        {MODE, CMD_CODE, TX_BITS, WR_DATA, TX_COUNT, rlen, cidx, rpat} = '0;
        MASK_RECEIVE_TIMER = 8'h04;
        NO_RESPONSE_TIMER = 16'h0028;
        TX_WATER = 5'h04;
        RX_WATER = 5'h01;
        void'($urandom(32'h72be317b));
        repeat (6) @(negedge CORE_CLK);
        RST = 1'b0;
        for (int m = 0; m < 4; m++) begin
            MODE = m[1:0];
            cmd(`NTS_CMD_PRESET);
            @(negedge CORE_CLK);
            check(PRESET_OPTS, 8'h11 << m);
        end
        $display("test preset done");
        EN = 1'b1;
        OSC_OK = 1'b1;
        wait_irq(0, 1);
        check(READY, 1'b1);
        check(irq_cnt[0], 1);
        $display("test ready done");
        // The 5 ms field settling is the host's business and would dwarf the run.
        {RX_EN, TX_EN} = 2'h3;
        ANTCL = 1'b1;
        NO_CRC_RX = 1'b1;
        send(`NTS_CMD_REQA);
        wait_irq(6, b[6] + 1);
        check(RX_ON, 1'b0);
        send(`NTS_CMD_WUPA);
        wait_irq(6, b[6] + 1);
        $display("test short frames done");
        ANTCL = 1'b0;
        NO_CRC_RX = 1'b0;
        cmd(`NTS_CMD_CLEAR);
        TX_COUNT = 13'h0002;
        rpat = 16'($urandom);
        {rlen, cidx} = 10'h21f;
        crc = `NTS_CRC_INIT;
        repeat (2) begin
            d = 8'($urandom);
            put(d);
            crc = crc_a(crc, d);
        end
        @(negedge CORE_CLK);
        WR_VALID = 1'b0;
        push_byte(crc[7:0]);
        push_byte(crc[15:8]);
        byte_q.push_back(rpat[7:0]);
        byte_q.push_back(rpat[15:8]);
        send(`NTS_CMD_TX_CRC);
        wait_irq(2, b[2] + 1);
        repeat (3) @(negedge CORE_CLK);
        check(FIFO_COUNT, 5'h02);
        crc = crc_a(crc_a(`NTS_CRC_INIT, rpat[7:0]), rpat[15:8]);
        check(ERR_FLAGS[`NTS_ERR_CRC], crc != 16'h0000);
        check(irq_cnt[5] - b[5], 1);
        drain();
        $display("test crc frame and reply done");
        NO_CRC_RX = 1'b1;
        {rlen, cidx} = 10'h103;
        for (int a = 1; a >= 0; a--) begin
            ANTCL = a[0];
            byte_q.push_back(rpat[7:0]);
            send(`NTS_CMD_REQA);
            wait_irq(2, b[2] + 1);
            check(irq_cnt[4] - b[4], 1);
            check(irq_cnt[3] - b[3], !a[0]);
            check(ERR_FLAGS[`NTS_ERR_FRAME], !a[0]);
            drain();
        end
        $display("test collision done");
        rlen = 5'h00;
        cmd(`NTS_CMD_CLEAR);
        TX_COUNT = 13'h0010;
        repeat (16) put(8'($urandom));
        @(negedge CORE_CLK);
        WR_VALID = 1'b0;
        check(WR_READY, 1'b0);
        @(negedge CORE_CLK);
        check(FIFO_COUNT, 5'h10);
        send(`NTS_CMD_TX_NOCRC);
        check(irq_cnt[5] - b[5], 1);
        wait_irq(6, b[6] + 1);
        $display("test long frame done");
        // Bit-oriented frame: one full byte and four bits out, a reply that ends mid-byte.
        ANTCL = 1'b1;
        cmd(`NTS_CMD_CLEAR);
        {TX_COUNT, TX_BITS, rlen, cidx} = {13'h0002, 3'h4, 10'h19f};
        put(8'($urandom));
        put({4'h0, 4'($urandom)});
        repeat (5) void'(bit_q.pop_back());
        @(negedge CORE_CLK);
        WR_VALID = 1'b0;
        byte_q.push_back(rpat[7:0]);
        byte_q.push_back({4'h0, rpat[11:8]});
        send(`NTS_CMD_TX_NOCRC);
        repeat (20) @(negedge CORE_CLK);
        check(RX_ON, 1'b0);
        repeat (30) @(negedge CORE_CLK);
        check(RX_ON, 1'b1);
        wait_irq(2, b[2] + 1);
        drain();
        $display("test split byte done");
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
